/* verilog/cit_timing.v */
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// RL1 - Nonzero direct page low byte adds cycle
// RL2 - Sixteen-bit data immediate adds one byte
// RL3 - Taken branch adds two cycles
// RL4 - Short and long branch displacement forms
// RL5 - Distinct opcodes select accumulator A or B
// RL6 - Push: twelve base, two or one each
// RL7 - Pull: fourteen base, three each, four DP
// RL8 - First block odd count: 7+7(i/2)+4
// RL9 - Second block odd count: 9+7(i/2)+5
// RL10 - Wide divide adds sixteen cycles
// RL11 - Wide multiply adds eight cycles
// RL12 - Sixteen-bit index immediate adds one byte
// RL13 - Sixteen-bit data form one byte longer
// RL14 - Real counts exceed fastest figures with stalls
// RL15 - Width flags sampled at decode time
`include "cit_consts.vh"

module cit_timing #(
  parameter CW = 20, // Cycle count width
  parameter NW = 16 // Block byte count width
) (
  // One clock; reset is synchronous and active low
  input wire clk,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  // Strobes are one-cycle pulses, never both at once
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Decode request from the core, same clock
  input wire dec_req,
  // Class picks the cycle formula that applies
  input wire [3:0] dec_class,
  // Fastest-mode figures from the opcode table
  input wire [CW-1:0] dec_base_cyc,
  input wire [3:0] dec_base_len,
  // Qualifiers of the opcode being decoded
  input wire dec_uses_dp,
  input wire dec_data16,
  input wire dec_acc_b,
  // Branch outcome and divide/multiply operand width, known when the request is made
  input wire dec_taken,
  input wire dec_wide,
  // Push or pull list, one bit per register
  input wire [7:0] dec_regmask,
  // Byte count of a block transfer
  input wire [NW-1:0] dec_count,
  // Displacement bytes of a branch
  input wire [15:0] dec_operand,
  // Stalls measured by the bus unit
  input wire [7:0] dec_stall_cyc,
  // Decode answer
  output reg res_valid,
  output reg [CW-1:0] res_cycles,
  output reg [3:0] res_bytes,
  // Opcode form flags
  output reg res_acc_b,
  output reg res_long_br,
  output reg [15:0] res_disp,
  // Live copies of the software-held state
  output wire m_flag,
  output wire x_flag,
  output wire [15:0] direct_page_base
);

  // Software-held width flags and direct page base
  reg [1:0] flags_r;
  reg [15:0] dpage_r;
  // Count of decodes taken, visible to software
  reg [31:0] ndec_r;
  // Next values of the answer
  reg [CW-1:0] cyc_nxt;
  reg [3:0] len_nxt;
  reg [15:0] disp_nxt;
  // Register list split by weight
  reg [7:0] main_push;
  reg [7:0] bank_push;
  reg [7:0] main_pull;
  // Half of the block byte count
  wire [NW-1:0] half_cnt;
  // Odd count selects the fixed head and tail
  wire cnt_odd;
  // Direct page low byte off zero
  wire dp_low_nz;

  // Flag and page outputs straight from their registers
  assign m_flag = flags_r[`CIT_FLD_M];
  assign x_flag = flags_r[`CIT_FLD_X];
  assign direct_page_base = dpage_r;
  // Integer half and parity of the byte count
  assign half_cnt = {1'b0, dec_count[NW-1:1]};
  assign cnt_odd = dec_count[0];
  // Low byte only; the high byte never costs a cycle
  assign dp_low_nz = |dpage_r[7:0]; // RL1

  // Number of set bits in a register list
  function [CW-1:0] pop8;
    input [7:0] v;
    // Fixed eight-bit loop, unrolls to an adder tree
    integer k;
    begin
      pop8 = {CW{1'b0}};
      for (k = 0; k < 8; k = k + 1) begin
        pop8 = pop8 + {{(CW-1){1'b0}}, v[k]};
      end
    end
  endfunction

  // Seven cycles per byte pair of a block transfer
  function [CW-1:0] pairs7;
    input [NW-1:0] h;
    begin
      // Kept to CW bits; larger products wrap
      pairs7 = `CIT_BLK_STEP * {{(CW-NW){1'b0}}, h};
    end
  endfunction

  // Register groups by cost
  always @* begin
    // Zero first so every bit is assigned on every path
    main_push = 8'h00;
    bank_push = 8'h00;
    main_pull = 8'h00;
    // Push: A, B, X, Y, DP and status weigh two each
    main_push[`CIT_RB_A] = dec_regmask[`CIT_RB_A];
    main_push[`CIT_RB_B] = dec_regmask[`CIT_RB_B];
    main_push[`CIT_RB_X] = dec_regmask[`CIT_RB_X];
    main_push[`CIT_RB_Y] = dec_regmask[`CIT_RB_Y];
    main_push[`CIT_RB_DP] = dec_regmask[`CIT_RB_DP];
    main_push[`CIT_RB_STAT] = dec_regmask[`CIT_RB_STAT];
    // Bank registers weigh one cycle each
    bank_push[`CIT_RB_DBANK] = dec_regmask[`CIT_RB_DBANK];
    bank_push[`CIT_RB_PBANK] = dec_regmask[`CIT_RB_PBANK];
    // Pull: DP costs four on its own; program bank cannot be pulled
    main_pull = main_push;
    main_pull[`CIT_RB_DP] = 1'b0;
    // Data bank joins the three-cycle group
    main_pull[`CIT_RB_DBANK] = dec_regmask[`CIT_RB_DBANK];
  end

  // Cycle count of the instruction being decoded
  // Table figure stands unless a class formula replaces it
  always @* begin
    cyc_nxt = dec_base_cyc;
    case (dec_class)
      // Short and long branches
      `CIT_CL_BRS, `CIT_CL_BRL: begin
        // Fall-through is the table figure
        if (dec_taken) begin
          cyc_nxt = dec_base_cyc + `CIT_BR_TAKEN; // RL3
        end
      end
      // Push cost depends on the list alone
      `CIT_CL_PUSH: begin
        cyc_nxt = `CIT_PUSH_BASE + `CIT_PUSH_MAIN * pop8(main_push)
                + `CIT_PUSH_BANK * pop8(bank_push); // RL6
      end
      // Pull cost, direct page weighed apart
      `CIT_CL_PULL: begin
        cyc_nxt = `CIT_PULL_BASE + `CIT_PULL_MAIN * pop8(main_pull); // RL7
        // Direct page pull costs four
        if (dec_regmask[`CIT_RB_DP]) begin
          cyc_nxt = cyc_nxt + `CIT_PULL_DP; // RL7
        end
      end
      // First block transfer
      `CIT_CL_BLK1: begin
        // Even counts follow the table base plus the pair cost
        if (cnt_odd) begin
          cyc_nxt = `CIT_BLK1_HEAD + pairs7(half_cnt) + `CIT_BLK1_TAIL; // RL8
        end else begin
          cyc_nxt = dec_base_cyc + pairs7(half_cnt);
        end
      end
      // Second block transfer, longer head and tail
      `CIT_CL_BLK2: begin
        // Even counts follow the table base plus the pair cost
        if (cnt_odd) begin
          cyc_nxt = `CIT_BLK2_HEAD + pairs7(half_cnt) + `CIT_BLK2_TAIL; // RL9
        end else begin
          cyc_nxt = dec_base_cyc + pairs7(half_cnt);
        end
      end
      // Divide: wide operands cost sixteen more
      `CIT_CL_DIV: begin
        if (dec_wide) begin
          cyc_nxt = dec_base_cyc + `CIT_DIV_WIDE; // RL10
        end
      end
      // Multiply: wide operands cost eight more
      `CIT_CL_MUL: begin
        if (dec_wide) begin
          cyc_nxt = dec_base_cyc + `CIT_MUL_WIDE; // RL11
        end
      end
      // Plain and immediate classes keep the table figure
      default: begin
        cyc_nxt = dec_base_cyc;
      end
    endcase
    // Direct page modes pay one more when the low byte is off zero
    if (dec_uses_dp && dp_low_nz) begin
      cyc_nxt = cyc_nxt + `CIT_DP_EXTRA; // RL1
    end
    // Queue refill, odd address and byte-wide bus stalls
    // Added as measured; stalls are not predicted here
    cyc_nxt = cyc_nxt + {{(CW-8){1'b0}}, dec_stall_cyc}; // RL14
  end

  // Byte length, flags taken as they stand at decode
  // At most one byte is added; the tests are exclusive
  always @* begin
    len_nxt = dec_base_len;
    if (dec_class == `CIT_CL_IMMD && !m_flag) begin
      // Two-byte data immediate
      len_nxt = dec_base_len + 4'h1; // RL2 RL15
    end else if (dec_class == `CIT_CL_IMMX && !x_flag) begin
      // Two-byte index immediate
      len_nxt = dec_base_len + 4'h1; // RL12 RL15
    end else if (dec_data16 && !m_flag) begin
      // Sixteen-bit memory data
      len_nxt = dec_base_len + 4'h1; // RL13 RL15
    end
  end

  // Branch displacement, sign extended from the short form
  always @* begin
    if (dec_class == `CIT_CL_BRS) begin
      // Short form: eight bits, sign extended
      disp_nxt = {{8{dec_operand[7]}}, dec_operand[7:0]}; // RL4
    end else if (dec_class == `CIT_CL_BRL) begin
      // Long form is already sixteen bits
      disp_nxt = dec_operand; // RL4
    end else begin
      // Other classes carry no displacement
      disp_nxt = 16'h0000;
    end
  end

  // Answer registers, one cycle after the request
  always @(posedge clk) begin
    if (!rstn) begin
      // Answer cleared while reset is low
      res_valid <= 1'b0;
      res_cycles <= {CW{1'b0}};
      res_bytes <= 4'h0;
      res_acc_b <= 1'b0;
      res_long_br <= 1'b0;
      res_disp <= 16'h0000;
    end else begin
      // Valid follows the request by one cycle
      res_valid <= dec_req;
      // Hold last answer when idle
      // Fields stay so software can read them later
      if (dec_req) begin
        res_cycles <= cyc_nxt;
        res_bytes <= len_nxt;
        res_acc_b <= dec_acc_b; // RL5
        res_long_br <= (dec_class == `CIT_CL_BRL); // RL4
        res_disp <= disp_nxt;
      end
    end
  end

  // Decode counter
  // Software reads it to see how many decodes ran
  always @(posedge clk) begin
    if (!rstn) begin
      // Held at zero in reset; wraps after all ones
      ndec_r <= 32'h00000000;
    end else if (dec_req) begin
      ndec_r <= ndec_r + 32'h00000001;
    end
  end

  // Register writes
  // Writes to read-only offsets change nothing
  always @(posedge clk) begin
    if (!rstn) begin
      // Both widths back to eight bits, page zero
      flags_r <= `CIT_FLAGS_RST;
      dpage_r <= `CIT_DPAGE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `CIT_REG_FLAGS: begin
          // Bits above the two flags are dropped
          flags_r <= reg_wdata[1:0];
        end
        `CIT_REG_DPAGE: begin
          // Full sixteen-bit base
          dpage_r <= reg_wdata[15:0];
        end
        default: begin
          // Read-only and unmapped: ignored
          flags_r <= flags_r;
        end
      endcase
    end
  end

  // Register reads, data in the next cycle only
  // Registered so the read answer never glitches
  always @(posedge clk) begin
    if (!rstn) begin
      // Zero outside the answer cycle
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CIT_REG_FLAGS: begin
          // Width flags in the low two bits
          reg_rdata <= {30'h0000000, flags_r};
        end
        `CIT_REG_DPAGE: begin
          // Direct page base, zero extended
          reg_rdata <= {16'h0000, dpage_r};
        end
        `CIT_REG_CYC: begin
          // Last cycle count answered
          reg_rdata <= {{(32-CW){1'b0}}, res_cycles};
        end
        `CIT_REG_LEN: begin
          // Length and opcode form flags
          reg_rdata <= {22'h00000, res_long_br, res_acc_b, 4'h0, res_bytes};
        end
        `CIT_REG_NDEC: begin
          // Decodes taken since reset
          reg_rdata <= ndec_r;
        end
        default: begin
          // Unmapped reads return zero
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      // No strobe: drive zero
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // cit_timing

/* inc/cit_consts.vh */
`ifndef CIT_CONSTS_VH
`define CIT_CONSTS_VH

// Register byte offsets
`define CIT_REG_FLAGS 8'h00
`define CIT_REG_DPAGE 8'h04
`define CIT_REG_CYC 8'h08
`define CIT_REG_LEN 8'h0C
`define CIT_REG_NDEC 8'h10

// Flag register fields and reset values
`define CIT_FLD_M 0
`define CIT_FLD_X 1
`define CIT_FLAGS_RST 2'h3
`define CIT_DPAGE_RST 16'h0000

// Length register fields
`define CIT_FLD_ACCB 8
`define CIT_FLD_BRL 9

// Instruction classes
`define CIT_CL_PLAIN 4'h0
`define CIT_CL_IMMD 4'h1
`define CIT_CL_IMMX 4'h2
`define CIT_CL_BRS 4'h3
`define CIT_CL_BRL 4'h4
`define CIT_CL_PUSH 4'h5
`define CIT_CL_PULL 4'h6
`define CIT_CL_BLK1 4'h7
`define CIT_CL_BLK2 4'h8
`define CIT_CL_DIV 4'h9
`define CIT_CL_MUL 4'hA

// Register list bit positions (push and pull masks)
`define CIT_RB_A 0
`define CIT_RB_B 1
`define CIT_RB_X 2
`define CIT_RB_Y 3
`define CIT_RB_DP 4
`define CIT_RB_DBANK 5
`define CIT_RB_PBANK 6
`define CIT_RB_STAT 7

// Cycle figures
`define CIT_DP_EXTRA 20'h00001
`define CIT_BR_TAKEN 20'h00002
`define CIT_PUSH_BASE 20'h0000C
`define CIT_PUSH_MAIN 20'h00002
`define CIT_PUSH_BANK 20'h00001
`define CIT_PULL_BASE 20'h0000E
`define CIT_PULL_MAIN 20'h00003
`define CIT_PULL_DP 20'h00004
`define CIT_BLK_STEP 20'h00007
`define CIT_BLK1_HEAD 20'h00007
`define CIT_BLK1_TAIL 20'h00004
`define CIT_BLK2_HEAD 20'h00009
`define CIT_BLK2_TAIL 20'h00005
`define CIT_DIV_WIDE 20'h00010
`define CIT_MUL_WIDE 20'h00008

`endif

/* verification/cit_timing_sva.sv */
`timescale 1ns/10ps
// Decode answer checks on the top ports
module cit_timing_sva #(
  parameter CW = 20,
  parameter NW = 16
) (
  input wire clk,
  input wire rstn,
  input wire dec_req,
  input wire [3:0] dec_class,
  input wire [CW-1:0] dec_base_cyc,
  input wire [3:0] dec_base_len,
  input wire dec_uses_dp,
  input wire dec_data16,
  input wire dec_acc_b,
  input wire dec_taken,
  input wire dec_wide,
  input wire [15:0] dec_operand,
  input wire [7:0] dec_stall_cyc,
  input wire res_valid,
  input wire [CW-1:0] res_cycles,
  input wire [3:0] res_bytes,
  input wire res_acc_b,
  input wire [15:0] res_disp,
  input wire m_flag,
  input wire x_flag,
  input wire [15:0] direct_page_base
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Request with no extra cycles, so the class figure is seen alone
  wire q = dec_req & ~dec_uses_dp & ~|dec_stall_cyc;
  sequence s_lone_req;
    dec_req ##1 !dec_req;
  endsequence
  a_valid_pulse: assert property (s_lone_req |-> res_valid ##1 !res_valid)
    else $error("answer pulse wrong");
  a_dp_extra: assert property (dec_req && dec_class == 4'h0 && dec_uses_dp &&
    |direct_page_base[7:0] && !dec_stall_cyc |=> res_cycles == $past(dec_base_cyc) + 1)
    else $error("direct page cycle missing");
  a_imm_len: assert property (dec_req && dec_class == 4'h1 && !m_flag
    |=> res_bytes == $past(dec_base_len) + 4'h1) else $error("data immediate length");
  a_idx_len: assert property (dec_req && dec_class == 4'h2 && !x_flag
    |=> res_bytes == $past(dec_base_len) + 4'h1) else $error("index immediate length");
  a_data_len: assert property (dec_req && dec_class == 4'h0 && dec_data16 && !m_flag
    |=> res_bytes == $past(dec_base_len) + 4'h1) else $error("wide data length");
  a_br_taken: assert property (q && dec_class == 4'h3 && dec_taken
    |=> res_cycles == $past(dec_base_cyc) + 2) else $error("taken branch cycles");
  a_short_disp: assert property (dec_req && dec_class == 4'h3
    |=> res_disp == {{8{$past(dec_operand[7])}}, $past(dec_operand[7:0])})
    else $error("short displacement");
  a_acc_sel: assert property (dec_req |=> res_acc_b == $past(dec_acc_b))
    else $error("accumulator select");
  a_div_wide: assert property (q && dec_class == 4'h9 && dec_wide
    |=> res_cycles == $past(dec_base_cyc) + 16) else $error("wide divide cycles");
endmodule // cit_timing_sva

bind cit_timing cit_timing_sva #(.CW(CW), .NW(NW)) u_sva (.*);

/* verification/cit_core_model.sv */
`timescale 1ns/10ps
// Core side: issues one decode request per call
module cit_core_model (
  input wire clk,
  output reg dec_req,
  output reg [3:0] dec_class,
  output reg [19:0] dec_base_cyc,
  output wire [3:0] dec_base_len,
  output reg dec_uses_dp,
  output reg dec_data16,
  output reg dec_acc_b,
  output reg dec_taken,
  output reg dec_wide,
  output reg [7:0] dec_regmask,
  output reg [15:0] dec_count,
  output reg [15:0] dec_operand,
  output reg [7:0] dec_stall_cyc
);
  // Table length fixed, so any growth is the decoder's own
  assign dec_base_len = 4'h2;
  initial begin
    {dec_req, dec_class, dec_base_cyc, dec_count, dec_operand, dec_regmask} = 65'h0;
    {dec_acc_b, dec_wide, dec_taken, dec_uses_dp, dec_data16, dec_stall_cyc} = 13'h0;
  end
  // Flags f: acc_b, wide, taken, dp, data16, then stall count
  task go(input [3:0] c, input [19:0] bc, input [15:0] n, input [7:0] mk, input [7:0] f);
    begin
      @(posedge clk);
      dec_req <= 1'b1;
      dec_class <= c;
      dec_base_cyc <= bc;
      dec_count <= n;
      dec_operand <= n;
      dec_regmask <= mk;
      {dec_acc_b, dec_wide, dec_taken, dec_uses_dp, dec_data16} <= f[7:3];
      dec_stall_cyc <= {5'h0, f[2:0]};
      @(posedge clk);
      dec_req <= 1'b0;
    end
  endtask
endmodule // cit_core_model

/* verification/tb_cit_timing.sv */
`timescale 1ns/10ps
module tb_cit_timing;
  reg clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  wire [31:0] reg_rdata;
  wire res_valid, res_acc_b, res_long_br, m_flag, x_flag, dec_req, dec_uses_dp;
  wire dec_data16, dec_acc_b, dec_taken, dec_wide;
  wire [19:0] res_cycles, dec_base_cyc;
  wire [3:0] res_bytes, dec_class, dec_base_len;
  wire [15:0] res_disp, direct_page_base, dec_count, dec_operand;
  wire [7:0] dec_regmask, dec_stall_cyc;
  integer error_cnt = 0, n_tests = 0, cyc = 0;
  cit_timing uut (.*);
  cit_core_model cm (.*);
  initial forever #4 clk = ~clk;
  task report_and_stop;
    begin
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Hang guard, far above the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  task dec(input [3:0] c, input [19:0] bc, input [15:0] n, input [7:0] mk, input [7:0] f,
    input [19:0] ec, input [3:0] el);
    begin
      cm.go(c, bc, n, mk, f);
      #1;
      chk(res_valid, 1);
      chk(res_cycles, ec);
      chk(res_bytes, el);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h3);
    rd(8'h04, 32'h0);
    chk(m_flag, 1);
    chk(x_flag, 1);
    chk(direct_page_base, 32'h0);
    rd(8'h20, 32'h0);
    wr(8'h04, 32'h100);
    dec(4'h0, 20'hA, 16'h0, 8'h00, 8'h10, 20'hA, 4'h2);
    wr(8'h04, 32'h101);
    dec(4'h0, 20'hA, 16'h0, 8'h00, 8'h10, 20'hB, 4'h2);
    chk(direct_page_base, 32'h101);
    dec(4'h0, 20'hA, 16'h0, 8'h00, 8'h13, 20'hE, 4'h2);
    wr(8'h00, 32'h0);
    dec(4'h1, 20'h5, 16'h0, 8'h00, 8'h00, 20'h5, 4'h3);
    dec(4'h2, 20'h5, 16'h0, 8'h00, 8'h00, 20'h5, 4'h3);
    dec(4'h0, 20'h5, 16'h0, 8'h00, 8'h08, 20'h5, 4'h3);
    wr(8'h00, 32'h2);
    dec(4'h2, 20'h5, 16'h0, 8'h00, 8'h00, 20'h5, 4'h2);
    chk(m_flag, 0);
    chk(x_flag, 1);
    dec(4'h1, 20'h5, 16'h0, 8'h00, 8'h00, 20'h5, 4'h3);
    wr(8'h00, 32'h1);
    dec(4'h0, 20'h5, 16'h0, 8'h00, 8'h08, 20'h5, 4'h2);
    dec(4'h3, 20'h4, 16'h80, 8'h00, 8'h00, 20'h4, 4'h2);
    chk(res_disp, 32'hFF80);
    dec(4'h3, 20'h4, 16'h5, 8'h00, 8'h20, 20'h6, 4'h2);
    dec(4'h4, 20'h5, 16'h8000, 8'h00, 8'h20, 20'h7, 4'h2);
    chk(res_disp, 32'h8000);
    chk(res_long_br, 1);
    dec(4'h5, 20'h0, 16'h0, 8'h81, 8'h00, 20'h10, 4'h2);
    dec(4'h5, 20'h0, 16'h0, 8'hFF, 8'h00, 20'h1A, 4'h2);
    dec(4'h6, 20'h0, 16'h0, 8'hFF, 8'h00, 20'h24, 4'h2);
    dec(4'h6, 20'h0, 16'h0, 8'h50, 8'h00, 20'h12, 4'h2);
    dec(4'h7, 20'h0, 16'h5, 8'h00, 8'h00, 20'h19, 4'h2);
    dec(4'h7, 20'h0, 16'h1, 8'h00, 8'h00, 20'hB, 4'h2);
    dec(4'h8, 20'h0, 16'h5, 8'h00, 8'h00, 20'h1C, 4'h2);
    dec(4'h8, 20'h10, 16'h4, 8'h00, 8'h00, 20'h1E, 4'h2);
    dec(4'h9, 20'h14, 16'h0, 8'h00, 8'h40, 20'h24, 4'h2);
    dec(4'hA, 20'h14, 16'h0, 8'h00, 8'h40, 20'h1C, 4'h2);
    dec(4'hA, 20'h14, 16'h0, 8'h00, 8'h80, 20'h14, 4'h2);
    chk(res_acc_b, 1);
    rd(8'h08, 32'h14);
    rd(8'h0C, 32'h102);
    rd(8'h10, 32'h17);
    report_and_stop;
  end
endmodule // tb_cit_timing
